// ==== adt_ctrl.sv ====
// Purpose: Converter control: registers, trigger select, result pair
// Assumes: Classic Wishbone slave, 32-bit data, 8-bit registers low lane
// Notes:   Analog core sits outside; it returns done with data
//
// Behaviour
// R1: Finished conversion result is stored across the two result bytes.
// R2: After low byte read, result holds until high byte read; a result done in the same cycle as the low byte read still loads.
// R3: Software reads low byte first, or high byte alone if left adjusted.
// R4: Adjust bit set gives left adjusted result; clear gives right adjusted.
// R5: Trigger source field acts only while auto trigger is enabled.
// R6: Rising edge of selected source flag starts a conversion.
// R7: Switching from a clear to a set source makes a trigger edge.
// R8: Free running selection never itself makes a trigger event.
// R9: Source codes: free, comparator, ext0, t0 A, t0 ovf, t1 B, ovf, cap.
// R10: Reserved trigger control bits read zero; software writes them zero.
// R11: Disable bit turns off pin input buffer and reads pin as zero.
// R12: Software should disable buffers of pins used only as analog.
// R13: Edges found by comparing flag with its previous cycle value.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
module adt_ctrl
  import adt_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  // Wishbone slave
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  input  wire logic                  wb_we_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire logic [adt_pkg::ADT_ADDR_W-1:0] wb_adr_in,
  input  wire logic [31:0]           wb_dat_in,
  output logic      [31:0]           wb_dat_out,
  output logic                       wb_ack_out,
  // Trigger source flags, bit i is source code i
  input  wire logic [7:0]            src_flags_in,
  // Analog core
  input  wire logic                  conv_done_in,
  input  wire logic [9:0]            conv_data_in,
  output logic                       conv_start_out,
  output logic                       conv_enable_out,
  output logic [3:0]                 chan_sel_out,
  output logic                       cmp_mux_en_out,
  // Pin inputs
  input  wire logic [7:0]            pin_raw_in,
  output logic [7:0]                 pin_value_out,
  output logic [7:0]                 buf_disable_out
);
  import adt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adt_bus_t    bus_q;
  adt_bus_t    bus_d;
  logic [7:0]  trig_q;
  logic [7:0]  trig_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  sel_q;
  logic [7:0]  sel_d;
  logic [7:0]  dis_q;
  logic [7:0]  dis_d;
  logic        done_q;
  logic        done_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        busy_q;
  logic        busy_d;
  logic        fin_q;
  logic        fin_d;
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic        rd_low;
  logic        rd_high;
  logic        trig_start;
  logic        start;
  logic [7:0]  res_low;
  logic [7:0]  res_high;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;

  assign idx   = wb_adr_in[ADT_ADDR_W-1:2];
  assign req   = wb_cyc_in & wb_stb_in & (bus_q == ADT_BUS_IDLE);
  assign wr    = req & wb_we_in & wb_sel_in[0];
  assign wbyte = wb_dat_in[7:0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_low  = 1'b0;
    rd_high = 1'b0;
    unique case (idx)
      ADT_IDX_TRIG_CTRL: rbyte = trig_q & ADT_TRIG_RW_MASK; // [R10]
      ADT_IDX_RES_LOW:
      begin
        rbyte  = res_low;
        rd_low = req & ~wb_we_in;
      end
      ADT_IDX_RES_HIGH:
      begin
        rbyte   = res_high;
        rd_high = req & ~wb_we_in;
      end
      ADT_IDX_CTRL_A:    rbyte = ctrl_q | {3'h0, done_q, 4'h0};
      ADT_IDX_IN_SEL:    rbyte = sel_q;
      ADT_IDX_PIN_DIS:   rbyte = dis_q;
      default:           rbyte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Register and bus next state
  // ----------------------------------------------------------------
  always_comb
  begin
    bus_d  = (bus_q == ADT_BUS_IDLE && wb_cyc_in && wb_stb_in)
           ? ADT_BUS_ACK : ADT_BUS_IDLE;
    rdat_d = req ? {24'h000000, rbyte} : rdat_q;
    trig_d = trig_q;
    ctrl_d = ctrl_q;
    sel_d  = sel_q;
    dis_d  = dis_q;
    if (wr)
    begin
      unique case (idx)
        ADT_IDX_TRIG_CTRL: trig_d = wbyte & ADT_TRIG_RW_MASK; // [R10]
        ADT_IDX_CTRL_A:    ctrl_d = wbyte & ADT_CTRL_RW_MASK;
        ADT_IDX_IN_SEL:    sel_d  = wbyte & ADT_SEL_RW_MASK;
        ADT_IDX_PIN_DIS:   dis_d  = wbyte;
        default:           trig_d = trig_q;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      bus_q  <= ADT_BUS_IDLE;
      rdat_q <= 32'h00000000;
      trig_q <= ADT_RST_BYTE;
      ctrl_q <= ADT_RST_BYTE;
      sel_q  <= ADT_RST_BYTE;
      dis_q  <= ADT_RST_BYTE;
    end
    else
    begin
      bus_q  <= bus_d;
      rdat_q <= rdat_d;
      trig_q <= trig_d;
      ctrl_q <= ctrl_d;
      sel_q  <= sel_d;
      dis_q  <= dis_d;
    end
  end

  // ----------------------------------------------------------------
  // Completion flag, busy and free running restart
  // ----------------------------------------------------------------
  always_comb
  begin
    done_d = done_q;
    if (wr && idx == ADT_IDX_CTRL_A && wbyte[ADT_CTRL_DONE_BIT])
      done_d = 1'b0;
    // Set wins over software clear
    if (conv_done_in)
      done_d = 1'b1;
    busy_d = busy_q;
    if (start)
      busy_d = 1'b1;
    if (conv_done_in)
      busy_d = 1'b0;
    fin_d  = conv_done_in;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      done_q <= 1'b0;
      busy_q <= 1'b0;
      fin_q  <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      busy_q <= busy_d;
      fin_q  <= fin_d;
    end
  end

  assign wb_ack_out = (bus_q == ADT_BUS_ACK);
  assign wb_dat_out = rdat_q;

  // ----------------------------------------------------------------
  // Trigger and result
  // ----------------------------------------------------------------
  adt_trig u_trig (
    .mclk_in      (mclk_in),
    .reset_in     (reset_in),
    .auto_en_in   (ctrl_q[ADT_CTRL_ATE_BIT]),
    .conv_en_in   (ctrl_q[ADT_CTRL_EN_BIT]),
    .src_sel_in   (adt_src_t'(trig_q[2:0])),
    .src_flags_in (src_flags_in),
    .start_out    (trig_start)
  );

  // Free running restarts on completion, never on the flag level
  assign start = ~busy_q & (trig_start
               | (ctrl_q[ADT_CTRL_ATE_BIT] & ctrl_q[ADT_CTRL_EN_BIT]
                  & (trig_q[2:0] == ADT_SRC_FREE) & fin_q)); // [R5] [R8]

  adt_result u_res (
    .mclk_in     (mclk_in),
    .reset_in    (reset_in),
    .done_in     (conv_done_in),
    .data_in     (conv_data_in),
    .left_adj_in (sel_q[ADT_SEL_LADJ_BIT]),
    .rd_low_in   (rd_low),
    .rd_high_in  (rd_high),
    .low_out     (res_low),
    .high_out    (res_high),
    .locked_out  ()
  );

  assign conv_start_out  = start;
  assign conv_enable_out = ctrl_q[ADT_CTRL_EN_BIT];
  assign chan_sel_out    = sel_q[3:0];
  assign cmp_mux_en_out  = trig_q[ADT_TRIG_CMP_MUX_BIT];
  assign buf_disable_out = dis_q; // [R11]
  assign pin_value_out   = pin_raw_in & ~dis_q; // [R11]

  property p_pin_zero;
    @(posedge mclk_in) disable iff (reset_in)
    (wr && idx == ADT_IDX_PIN_DIS) |=> ((pin_value_out & dis_q) == 8'h00
      && buf_disable_out == $past(wbyte));
  endproperty
  a_pin_zero: assert property (p_pin_zero) // [R11]
    else $error("Disabled pin input not zero");

  property p_resv;
    @(posedge mclk_in) disable iff (reset_in)
    (wr && idx == ADT_IDX_TRIG_CTRL) |=> ((trig_q & 8'hb8) == 8'h00);
  endproperty
  a_resv: assert property (p_resv) // [R10]
    else $error("Reserved trigger bits stored");

  property p_ack;
    @(posedge mclk_in) disable iff (reset_in)
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) // Wishbone answer timing, decided for this implementation
    else $error("Bus answer not one cycle after request");

  // ----------------------------------------------------------------
  // Trigger, read and completion flag checks
  // ----------------------------------------------------------------
  property p_free_select;
    @(posedge mclk_in) disable iff (reset_in)
    (trig_q[2:0] == ADT_SRC_FREE && $past(trig_q[2:0]) != ADT_SRC_FREE
     && !fin_q) |-> !conv_start_out;
  endproperty
  a_free_select: assert property (p_free_select) // [R8]
    else $error("Selecting free running made a start");

  property p_start_enable;
    @(posedge mclk_in) disable iff (reset_in)
    conv_start_out |-> (ctrl_q[ADT_CTRL_EN_BIT] && ctrl_q[ADT_CTRL_ATE_BIT]
      && !busy_q);
  endproperty
  a_start_enable: assert property (p_start_enable) // [R5]
    else $error("Start while disabled or busy");

  property p_trig_read;
    @(posedge mclk_in) disable iff (reset_in)
    (req && !wb_we_in && idx == ADT_IDX_TRIG_CTRL)
      |=> ((wb_dat_out[7:0] & ~ADT_TRIG_RW_MASK) == 8'h00);
  endproperty
  a_trig_read: assert property (p_trig_read) // [R10]
    else $error("Reserved trigger bits read as one");

  property p_high_read;
    @(posedge mclk_in) disable iff (reset_in)
    (req && !wb_we_in && idx == ADT_IDX_RES_HIGH)
      |=> (wb_dat_out == {24'h000000, $past(res_high)});
  endproperty
  a_high_read: assert property (p_high_read) // [R1]
    else $error("High result byte read wrong");

  property p_low_read;
    @(posedge mclk_in) disable iff (reset_in)
    (req && !wb_we_in && idx == ADT_IDX_RES_LOW)
      |=> (wb_dat_out == {24'h000000, $past(res_low)});
  endproperty
  a_low_read: assert property (p_low_read) // [R4]
    else $error("Low result byte read wrong");

  property p_done_set;
    @(posedge mclk_in) disable iff (reset_in)
    conv_done_in |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set) // [R1]
    else $error("Completion flag not set");
endmodule

// ==== adt_pkg.sv ====
// Purpose: Constants for the converter result and trigger control block
// Assumes: Classic Wishbone register access, 8-bit data in low lane
// Notes:   Offsets are word indices; byte address is four times the index
package adt_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] ADT_IDX_TRIG_CTRL = 8'h7b;
  localparam logic [7:0] ADT_IDX_RES_LOW   = 8'h78;
  localparam logic [7:0] ADT_IDX_RES_HIGH  = 8'h79;
  localparam logic [7:0] ADT_IDX_CTRL_A    = 8'h7a;
  localparam logic [7:0] ADT_IDX_IN_SEL    = 8'h7c;
  localparam logic [7:0] ADT_IDX_PIN_DIS   = 8'h7e;
  localparam int         ADT_ADDR_W        = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ADT_TRIG_CMP_MUX_BIT = 6;
  localparam int ADT_CTRL_EN_BIT      = 7;
  localparam int ADT_CTRL_ATE_BIT     = 5;
  localparam int ADT_CTRL_DONE_BIT    = 4;
  localparam int ADT_SEL_LADJ_BIT     = 5;
  localparam logic [7:0] ADT_TRIG_RW_MASK = 8'h47;
  localparam logic [7:0] ADT_CTRL_RW_MASK = 8'ha0;
  localparam logic [7:0] ADT_SEL_RW_MASK  = 8'h2f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADT_RST_BYTE = 8'h00;
  localparam logic [9:0] ADT_RST_RES  = 10'h000;

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ADT_SRC_FREE  = 3'b000,
    ADT_SRC_ACMP  = 3'b001,
    ADT_SRC_EXT0  = 3'b010,
    ADT_SRC_T0CA  = 3'b011,
    ADT_SRC_T0OV  = 3'b100,
    ADT_SRC_T1CB  = 3'b101,
    ADT_SRC_T1OV  = 3'b110,
    ADT_SRC_T1CAP = 3'b111
  } adt_src_t;

  // Bus slave states
  typedef enum logic [0:0] {
    ADT_BUS_IDLE = 1'b0,
    ADT_BUS_ACK  = 1'b1
  } adt_bus_t;

endpackage

// ==== adt_trig.sv ====
// Purpose: Auto trigger source selection and rising edge detection
// Assumes: Source flags are synchronous levels
// Notes:   One-cycle start pulse out
`timescale 1ns/10ps
module adt_trig
  import adt_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Control
  input  wire logic       auto_en_in,
  input  wire logic       conv_en_in,
  input  wire adt_src_t   src_sel_in,
  input  wire logic [7:0] src_flags_in,
  // Result
  output logic            start_out
);
  import adt_pkg::*;

  logic sel_flag;
  logic prev_q;
  logic prev_d;

  // ----------------------------------------------------------------
  // Selected flag; free running never edges
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_flag = (src_sel_in == ADT_SRC_FREE) ? 1'b0
             : src_flags_in[src_sel_in]; // [R8] [R9]
    prev_d   = sel_flag;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d; // [R13]
  end

  // Edge also arises from switching to a set source
  assign start_out = auto_en_in & conv_en_in & sel_flag & ~prev_q; // [R5] [R6] [R7]

  property p_edge_start;
    @(posedge mclk_in) disable iff (reset_in)
    (auto_en_in && conv_en_in && sel_flag && !$past(sel_flag)
     && !$past(reset_in)) |-> start_out;
  endproperty
  a_edge_start: assert property (p_edge_start) // [R6]
    else $error("Rising trigger edge gave no start");

  property p_no_auto;
    @(posedge mclk_in) disable iff (reset_in)
    !auto_en_in |-> !start_out;
  endproperty
  a_no_auto: assert property (p_no_auto) // [R5]
    else $error("Start without auto trigger enable");

  property p_free_quiet;
    @(posedge mclk_in) disable iff (reset_in)
    (src_sel_in == ADT_SRC_FREE) |-> !start_out;
  endproperty
  a_free_quiet: assert property (p_free_quiet) // [R8]
    else $error("Free running source made a trigger");

  property p_level_quiet;
    @(posedge mclk_in) disable iff (reset_in)
    (sel_flag && $stable(src_sel_in)) ##1 (sel_flag && $stable(src_sel_in))
      |-> !start_out;
  endproperty
  a_level_quiet: assert property (p_level_quiet) // [R13]
    else $error("Start on a steady high flag");
endmodule

// ==== adt_result.sv ====
// Purpose: Result byte pair with high byte lock and adjustment
// Assumes: Read strobes are one-cycle pulses
// Notes:   Lock opens on high byte read
`timescale 1ns/10ps
module adt_result
  import adt_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Converter side
  input  wire logic       done_in,
  input  wire logic [9:0] data_in,
  input  wire logic       left_adj_in,
  // Read strobes
  input  wire logic       rd_low_in,
  input  wire logic       rd_high_in,
  // Bytes
  output logic [7:0]      low_out,
  output logic [7:0]      high_out,
  output logic            locked_out
);
  import adt_pkg::*;

  logic [9:0] res_q;
  logic [9:0] res_d;
  logic       lock_q;
  logic       lock_d;

  // ----------------------------------------------------------------
  // Update and lock
  // ----------------------------------------------------------------
  always_comb
  begin
    lock_d = lock_q;
    res_d  = res_q;
    if (rd_low_in)
      lock_d = 1'b1; // [R2]
    if (rd_high_in)
      lock_d = 1'b0; // [R2]
    if (done_in && !lock_q)
      res_d = data_in; // [R1]
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      res_q  <= ADT_RST_RES;
      lock_q <= 1'b0;
    end
    else
    begin
      res_q  <= res_d;
      lock_q <= lock_d;
    end
  end

  // Left adjust puts bits 9:2 in high byte
  always_comb
  begin
    if (left_adj_in)
    begin
      high_out = res_q[9:2]; // [R4]
      low_out  = {res_q[1:0], 6'h00};
    end
    else
    begin
      high_out = {6'h00, res_q[9:8]}; // [R4]
      low_out  = res_q[7:0];
    end
  end
  assign locked_out = lock_q;

  property p_hold;
    @(posedge mclk_in) disable iff (reset_in)
    lock_q |=> $stable(res_q);
  endproperty
  a_hold: assert property (p_hold) // [R2]
    else $error("Result changed while locked");

  property p_load;
    @(posedge mclk_in) disable iff (reset_in)
    (done_in && !lock_q) |=> (res_q == $past(data_in));
  endproperty
  a_load: assert property (p_load) // [R1]
    else $error("Finished result not stored");
endmodule

// ==== adt_src_model.sv ====
// Purpose: Far side model: trigger source flags and analog core
// Assumes: Flags follow the bench request one cycle later
// Notes:   Data line shows inverted junk outside done pulse
`timescale 1ns/10ps
module adt_src_model
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // Bench controls
  input  wire logic [7:0]  flags_in,
  input  wire logic [9:0]  val_in,
  input  wire logic [3:0]  lat_in,
  // Design side
  input  wire logic        conv_start_in,
  output logic [7:0]       src_flags_out,
  output logic             conv_done_out,
  output logic [9:0]       conv_data_out,
  // Counts
  output logic [15:0]      starts_out,
  output logic [15:0]      dones_out
);
  logic [4:0] cnt_q;
  logic       run_q;

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      src_flags_out <= 8'h00;
      conv_done_out <= 1'b0;
      conv_data_out <= 10'h155;
      starts_out    <= 16'h0000;
      dones_out     <= 16'h0000;
      cnt_q         <= 5'h00;
      run_q         <= 1'b0;
    end
    else
    begin
      src_flags_out <= flags_in;
      conv_done_out <= 1'b0;
      conv_data_out <= ~conv_data_out;
      if (conv_start_in)
      begin
        starts_out <= starts_out + 16'h0001;
        run_q      <= 1'b1;
        cnt_q      <= {1'b0, lat_in} + 5'h01;
      end
      else if (run_q && cnt_q == 5'h00)
      begin
        run_q         <= 1'b0;
        conv_done_out <= 1'b1;
        conv_data_out <= val_in;
        dones_out     <= dones_out + 16'h0001;
      end
      else if (run_q)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: Byte address is four times the register index
// Notes:   Random data from a fixed seed
`timescale 1ns/10ps
module tb;
  import adt_pkg::*;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat_w;
  logic        ack;
  logic [7:0]  flags_rq = 8'h00, sflags, praw = 8'h00, pval, pdis, rd;
  logic [9:0]  val = 10'h000, cdata;
  logic [3:0]  lat = 4'h2, chan;
  logic        cstart, cdone, cen, cmux;
  logic [15:0] starts, dones, s0;
  integer      seed = 32'h5dfa8e3d;
  integer      bad_count = 0, tests_run = 0, i;
  logic [9:0]  v1, v2;

  always #10 mclk_in = ~mclk_in;

  adt_ctrl u_adt_ctrl (.mclk_in(mclk_in), .reset_in(reset_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_sel_in(sel),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_dat_out(rdat_w),
    .wb_ack_out(ack), .src_flags_in(sflags), .conv_done_in(cdone),
    .conv_data_in(cdata), .conv_start_out(cstart),
    .conv_enable_out(cen), .chan_sel_out(chan), .cmp_mux_en_out(cmux),
    .pin_raw_in(praw), .pin_value_out(pval), .buf_disable_out(pdis));
  adt_src_model u_adt_src_model (.mclk_in(mclk_in), .reset_in(reset_in),
    .flags_in(flags_rq), .val_in(val), .lat_in(lat),
    .conv_start_in(cstart), .src_flags_out(sflags),
    .conv_done_out(cdone), .conv_data_out(cdata),
    .starts_out(starts), .dones_out(dones));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (e !== g)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] r);
    integer n;
    @(posedge mclk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
    adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      chk("ack", 1, 0);
      end_sim();
    end
    r = rdat_w[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  function automatic logic [7:0] exp_res(input logic [9:0] v,
                                         input logic ladj, hi);
    if (ladj)
      return hi ? v[9:2] : {v[1:0], 6'h00};
    return hi ? {6'h00, v[9:8]} : v[7:0];
  endfunction

  task automatic rchk(input string nm, input logic [7:0] idx, e);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk(nm, {24'h0, e}, {24'h0, r});
  endtask

  task automatic wr(input logic [7:0] idx, d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask

  task automatic pulse(input int b, input logic [9:0] v);
    integer n;
    logic [15:0] d0;
    val <= v; lat <= 4'($random(seed));
    flags_rq <= 8'h00;
    repeat (3) @(posedge mclk_in);
    flags_rq[b] <= 1'b1;
    n = 0;
    d0 = dones;
    while (dones == d0 && n < 40)
    begin
      @(posedge mclk_in);
      n++;
    end
    if (dones == d0)
    begin
      chk("done", 1, 0);
      end_sim();
    end
    repeat (2) @(posedge mclk_in);
    flags_rq <= 8'h00;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    #(20 * 20000);
    chk("watchdog", 0, 1);
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    rchk("trig rst", ADT_IDX_TRIG_CTRL, 8'h00);
    rchk("low rst", ADT_IDX_RES_LOW, 8'h00);
    rchk("high rst", ADT_IDX_RES_HIGH, 8'h00);
    rchk("dis rst", ADT_IDX_PIN_DIS, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    wr(ADT_IDX_TRIG_CTRL, 8'hff);
    rchk("trig mask", ADT_IDX_TRIG_CTRL, 8'h47);
    chk("cmp mux", 1, cmux);
    $display("test registers done");
    for (i = 0; i < 6; i++)
    begin
      v1[7:0] = 8'($random(seed));
      wr(ADT_IDX_PIN_DIS, v1[7:0]);
      praw <= 8'($random(seed));
      repeat (2) @(posedge mclk_in);
      chk("pin value", {24'h0, praw & ~v1[7:0]}, {24'h0, pval});
      chk("buf dis", {24'h0, v1[7:0]}, {24'h0, pdis});
    end
    $display("test pin disable done");
    wr(ADT_IDX_CTRL_A, 8'ha0);
    chk("enable", 1, cen);
    for (i = 1; i < 8; i++)
    begin
      wr(ADT_IDX_TRIG_CTRL, 8'(i));
      s0 = starts;
      flags_rq <= 8'h1 << ((i % 7) + 1);
      repeat (4) @(posedge mclk_in);
      chk("other src", {16'h0, s0}, {16'h0, starts});
      pulse(i, 10'($random(seed)));
      chk("src start", {16'h0, s0 + 16'h1}, {16'h0, starts});
    end
    $display("test sources done");
    wr(ADT_IDX_TRIG_CTRL, 8'h01);
    flags_rq <= 8'h08;
    repeat (3) @(posedge mclk_in);
    s0 = starts;
    wr(ADT_IDX_TRIG_CTRL, 8'h03);
    repeat (12) @(posedge mclk_in);
    chk("switch edge", {16'h0, s0 + 16'h1}, {16'h0, starts});
    flags_rq <= 8'h00;
    repeat (20) @(posedge mclk_in);
    s0 = starts;
    wr(ADT_IDX_TRIG_CTRL, 8'h00);
    repeat (6) @(posedge mclk_in);
    chk("free select", {16'h0, s0}, {16'h0, starts});
    wr(ADT_IDX_CTRL_A, 8'h80);
    wr(ADT_IDX_TRIG_CTRL, 8'h02);
    s0 = starts;
    flags_rq <= 8'h04;
    repeat (6) @(posedge mclk_in);
    chk("auto off", {16'h0, s0}, {16'h0, starts});
    flags_rq <= 8'h00;
    wr(ADT_IDX_CTRL_A, 8'ha0);
    wr(ADT_IDX_TRIG_CTRL, 8'h01);
    $display("test trigger modes done");
    v1 = 10'($random(seed));
    v2 = ~v1;
    pulse(1, v1);
    rchk("right low", ADT_IDX_RES_LOW, exp_res(v1, 1'b0, 1'b0));
    pulse(1, v2);
    rchk("locked high", ADT_IDX_RES_HIGH, exp_res(v1, 1'b0, 1'b1));
    pulse(1, v2);
    rchk("new low", ADT_IDX_RES_LOW, exp_res(v2, 1'b0, 1'b0));
    rchk("new high", ADT_IDX_RES_HIGH, exp_res(v2, 1'b0, 1'b1));
    rchk("ctrl a", ADT_IDX_CTRL_A, 8'hb0);
    wr(ADT_IDX_CTRL_A, 8'hb0);
    rchk("done clr", ADT_IDX_CTRL_A, 8'ha0);
    wr(ADT_IDX_IN_SEL, 8'h25);
    rchk("in sel", ADT_IDX_IN_SEL, 8'h25);
    chk("chan", 5, chan);
    v1 = 10'h2c5;
    pulse(1, v1);
    rchk("left high", ADT_IDX_RES_HIGH, exp_res(v1, 1'b1, 1'b1));
    rchk("left low", ADT_IDX_RES_LOW, exp_res(v1, 1'b1, 1'b0));
    $display("test result done");
    end_sim();
  end
endmodule
